// ===== design/flash_protect_reset.sv
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Refuse program/erase on protected addresses
// - Protect bits change only by status write
// - Large codes protect upper/lower sixteenth to half
// - Bit four codes protect 4K-32K top/bottom
// - Zero code protects none; some codes all
// - Complement bit inverts the protected region
// - Lock pin never alters decoded protection
// - Lock pin low freezes protect bits
// - Other command after enable disarms reset
// - Soft reset clears volatile state, aborts
// - No command accepted during reset recovery
// - Security pages ignore array protection
// - Each security page locks independently
// - Writes need write-enable latch set
module flash_protect_reset (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic wp_n,
	input wire logic core_busy,
	input wire logic core_erase_active,
	output fp_pkg::op_req_t op_req,
	output logic core_abort
);
	// Cycles from the eighth busy cycle to the first idle one
	localparam int RST_TAIL = fp_pkg::RST_CYCLES - 7;

	// Pin synchronisers and frame capture
	logic [2:0] sck_q;
	logic [2:0] cs_q;
	logic [1:0] mosi_q;
	logic [1:0] wp_q;
	logic [2:0] bit_q;
	logic [2:0] nb_q;
	logic [7:0] sh_q;
	logic [7:0] opc_q;
	logic [23:0] addr_q;

	// Protection and volatile state
	logic [4:0] bp_q;
	logic protect_complement_bit_q;
	logic [2:0] lb_q;
	logic write_enable_latch_q;
	logic armed_q;
	logic esus_q;
	logic psus_q;
	logic [2:0] wrap_q;
	logic [7:0] crm_q;
	logic [fp_pkg::RST_CNT_W-1:0] rst_cnt_q;
	logic abort_q;
	fp_pkg::op_req_t op_q;
	logic ref_q;

	// Bus slave state
	logic wr_pend_q;
	logic [7:0] wa_q;
	logic [31:0] hrdata_q;
	logic [19:0] chk_addr_q;

	// Decode wires
	logic sck_rise;
	logic cs_sel;
	logic frame_start;
	logic frame_end;
	logic [7:0] byte_in;
	logic byte_done;
	logic rst_busy;
	logic exec;
	logic is_prog;
	logic is_chip;
	logic arr_op;
	logic arr_len_ok;
	logic [19:0] op_mask;
	logic [19:0] op_lo;
	logic [19:0] op_hi;
	logic hit_lo;
	logic hit_hi;
	logic hit;
	logic is_sec;
	logic [3:0] page;
	logic sec_lock;
	logic sec_ok;
	logic wr_ok;
	logic go_arr;
	logic go_sec;
	logic refused;
	logic wrsr;
	logic wp_open;
	logic soft_go;
	logic [7:0] sr_lo;
	logic [7:0] sr_hi;
	logic write_class;
	logic chk_hit;
	fp_pkg::op_kind_t kind;
	logic [15:0] stat16;
	logic ap;
	logic map_ok;
	logic [31:0] rd_val;

	// Pin sampling, two flops before any use
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sck_q <= 3'h0;
			cs_q <= 3'h7;
			mosi_q <= 2'h0;
			wp_q <= 2'h0;
		end
		else
		begin
			sck_q <= {sck_q[1:0], spi_sck};
			cs_q <= {cs_q[1:0], spi_cs_n};
			mosi_q <= {mosi_q[0], spi_mosi};
			wp_q <= {wp_q[0], wp_n};
		end
	end

	// Edges of the synchronised link
	assign sck_rise = sck_q[1] & ~sck_q[2];
	assign cs_sel = ~cs_q[1];
	assign frame_start = ~cs_q[1] & cs_q[2];
	assign frame_end = cs_q[1] & ~cs_q[2];
	assign byte_in = {sh_q[6:0], mosi_q[1]};
	assign byte_done = sck_rise & cs_sel & (bit_q == 3'h7);

	// Shift in opcode then trailing bytes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bit_q <= 3'h0;
			nb_q <= 3'h0;
			sh_q <= 8'h00;
			opc_q <= 8'h00;
			addr_q <= 24'h000000;
		end
		else if (frame_start)
		begin
			bit_q <= 3'h0;
			nb_q <= 3'h0;
		end
		else if (sck_rise & cs_sel)
		begin
			bit_q <= bit_q + 3'h1;
			sh_q <= byte_in;
			if (byte_done & (nb_q == 3'h0))
				opc_q <= byte_in;
			else if (byte_done)
				addr_q <= {addr_q[15:0], byte_in};
			if (byte_done & (nb_q != fp_pkg::NB_MAX))
				nb_q <= nb_q + 3'h1;
		end
	end

	// A command counts only on a byte boundary, outside reset recovery
	assign rst_busy = rst_cnt_q != '0;
	assign exec = frame_end & (bit_q == 3'h0) & (nb_q != 3'h0) & ~rst_busy;

	// Array operation decode and its address span
	assign is_prog = (opc_q == fp_pkg::OPC_PP) | (opc_q == fp_pkg::OPC_QPP);
	assign is_chip = (opc_q == fp_pkg::OPC_CE1) | (opc_q == fp_pkg::OPC_CE2);
	assign arr_op = is_prog | is_chip | (opc_q == fp_pkg::OPC_BE4)
		| (opc_q == fp_pkg::OPC_BE32) | (opc_q == fp_pkg::OPC_BE64);
	assign arr_len_ok = is_chip ? (nb_q == fp_pkg::NB_ONE) : (nb_q >= fp_pkg::NB_ADDR);
	assign op_mask = is_prog ? fp_pkg::MASK_PAGE
		: (opc_q == fp_pkg::OPC_BE4) ? fp_pkg::MASK_4K
		: (opc_q == fp_pkg::OPC_BE32) ? fp_pkg::MASK_32K
		: (opc_q == fp_pkg::OPC_BE64) ? fp_pkg::MASK_64K : fp_pkg::MASK_CHIP;
	assign op_lo = addr_q[19:0] & ~op_mask;
	assign op_hi = op_lo | op_mask;
	assign kind = is_prog ? fp_pkg::OP_PROG
		: (opc_q == fp_pkg::OPC_BE4) ? fp_pkg::OP_ER4K
		: (opc_q == fp_pkg::OPC_BE32) ? fp_pkg::OP_ER32K
		: (opc_q == fp_pkg::OPC_BE64) ? fp_pkg::OP_ER64K
		: is_chip ? fp_pkg::OP_CHIP
		: (opc_q == fp_pkg::OPC_SECP) ? fp_pkg::OP_SECP : fp_pkg::OP_SECE;

	// Protected regions are a prefix or suffix, so both ends suffice
	prot_decode #(.AW(fp_pkg::ADDR_W)) u_dec_lo (
		.bp(bp_q),
		.protect_complement_bit(protect_complement_bit_q),
		.addr(op_lo),
		.hit(hit_lo)
	);
	prot_decode #(.AW(fp_pkg::ADDR_W)) u_dec_hi (
		.bp(bp_q),
		.protect_complement_bit(protect_complement_bit_q),
		.addr(op_hi),
		.hit(hit_hi)
	);
	prot_decode #(.AW(fp_pkg::ADDR_W)) u_dec_chk (
		.bp(bp_q),
		.protect_complement_bit(protect_complement_bit_q),
		.addr(chk_addr_q),
		.hit(chk_hit)
	);
	assign hit = hit_lo | hit_hi;

	// Security pages: own address map and own lock bits
	assign is_sec = (opc_q == fp_pkg::OPC_SECP) | (opc_q == fp_pkg::OPC_SECE);
	assign page = addr_q[15:12];
	assign sec_lock = ((page == 4'h1) & lb_q[0]) | ((page == 4'h2) & lb_q[1])
		| ((page == 4'h3) & lb_q[2]);
	assign sec_ok = (addr_q[23:16] == 8'h00) & (addr_q[11:8] == 4'h0)
		& (page >= fp_pkg::SEC_PAGE_FIRST) & (page <= fp_pkg::SEC_PAGE_LAST)
		& ~sec_lock & (nb_q >= fp_pkg::NB_ADDR);

	// Acceptance of write-class commands
	assign wr_ok = write_enable_latch_q & ~core_busy;
	assign go_arr = exec & arr_op & arr_len_ok & wr_ok & ~hit;
	assign go_sec = exec & is_sec & wr_ok & sec_ok;
	assign refused = exec & (arr_op | is_sec) & ~(go_arr | go_sec);
	assign wrsr = exec & (opc_q == fp_pkg::OPC_WRSR) & (nb_q >= fp_pkg::NB_WRSR1) & wr_ok;
	assign wp_open = wp_q[1];
	assign write_class = arr_op | is_sec | (opc_q == fp_pkg::OPC_WRSR);
	assign soft_go = exec & (opc_q == fp_pkg::OPC_RST) & armed_q;
	assign sr_lo = (nb_q == fp_pkg::NB_WRSR1) ? addr_q[7:0] : addr_q[15:8];
	assign sr_hi = addr_q[7:0];

	// Non-volatile protect bits, kept across soft reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bp_q <= fp_pkg::BP_RST;
			protect_complement_bit_q <= fp_pkg::COMPLEMENT_RST;
			lb_q <= fp_pkg::LB_RST;
		end
		else if (wrsr)
		begin
			if (wp_open)
				bp_q <= sr_lo[fp_pkg::SR_BP_LSB +: 5];
			if (wp_open & (nb_q >= fp_pkg::NB_WRSR2))
				protect_complement_bit_q <= sr_hi[fp_pkg::SR_COMPLEMENT_BIT];
			if (nb_q >= fp_pkg::NB_WRSR2)
				lb_q <= lb_q | sr_hi[fp_pkg::SR_LB_LSB +: 3];
		end
	end

	// Write-enable latch and reset arming
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			write_enable_latch_q <= 1'b0;
			armed_q <= 1'b0;
		end
		else if (soft_go)
		begin
			write_enable_latch_q <= 1'b0;
			armed_q <= 1'b0;
		end
		else if (exec)
		begin
			armed_q <= opc_q == fp_pkg::OPC_RSTEN;
			if (opc_q == fp_pkg::OPC_WREN)
				write_enable_latch_q <= 1'b1;
			else if ((opc_q == fp_pkg::OPC_WRDI) | write_class)
				write_enable_latch_q <= 1'b0;
		end
	end

	// Suspend flags and wrap length
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			esus_q <= 1'b0;
			psus_q <= 1'b0;
			wrap_q <= 3'h0;
		end
		else if (soft_go)
		begin
			esus_q <= 1'b0;
			psus_q <= 1'b0;
			wrap_q <= 3'h0;
		end
		else if (exec)
		begin
			if ((opc_q == fp_pkg::OPC_SUSP) & core_busy & core_erase_active)
				esus_q <= 1'b1;
			if ((opc_q == fp_pkg::OPC_SUSP) & core_busy & ~core_erase_active)
				psus_q <= 1'b1;
			// Program resumes before erase
			if ((opc_q == fp_pkg::OPC_RESUME) & psus_q)
				psus_q <= 1'b0;
			if ((opc_q == fp_pkg::OPC_RESUME) & ~psus_q)
				esus_q <= 1'b0;
			if ((opc_q == fp_pkg::OPC_WRAP) & (nb_q == fp_pkg::NB_WRAP))
				wrap_q <= addr_q[fp_pkg::WRAP_LSB +: 3];
		end
	end

	// Recovery counter and abort pulse to the array core
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rst_cnt_q <= '0;
			abort_q <= 1'b0;
		end
		else
		begin
			abort_q <= soft_go;
			if (soft_go)
				rst_cnt_q <= fp_pkg::RST_CNT_W'(fp_pkg::RST_CYCLES);
			else if (rst_busy)
				rst_cnt_q <= rst_cnt_q - 1'b1;
		end
	end

	// Request to the array core, plus last-request record
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op_q <= '0;
			ref_q <= 1'b0;
		end
		else
		begin
			op_q.valid <= go_arr | go_sec;
			if (go_arr | go_sec | refused)
			begin
				op_q.kind <= kind;
				op_q.addr <= is_sec ? addr_q[19:0] : op_lo;
				ref_q <= refused;
			end
		end
	end

	// Status word as software sees it
	assign stat16 = {esus_q, protect_complement_bit_q, lb_q, psus_q, 3'h0, bp_q,
		write_enable_latch_q, core_busy | rst_busy};

	// Bus address phase decode and read mux
	assign ap = hsel & htrans[1] & hready;
	assign map_ok = haddr[31:8] == 24'h000000;
	assign rd_val = !map_ok ? 32'h00000000
		: (haddr[7:0] == fp_pkg::REG_STATUS) ? {14'h0000, rst_busy, armed_q, stat16}
		: (haddr[7:0] == fp_pkg::REG_MODE) ? {21'h000000, wrap_q, crm_q}
		: (haddr[7:0] == fp_pkg::REG_CHECK) ? {chk_hit, 11'h000, chk_addr_q}
		: (haddr[7:0] == fp_pkg::REG_LASTOP) ? {ref_q, 8'h00, op_q.kind, op_q.addr}
		: 32'h00000000;

	// Zero-wait slave: read data latched at the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wa_q <= 8'h00;
			hrdata_q <= 32'h00000000;
		end
		else
		begin
			wr_pend_q <= ap & hwrite & map_ok;
			if (ap)
				wa_q <= haddr[7:0];
			if (ap & ~hwrite)
				hrdata_q <= rd_val;
		end
	end

	// Data phase writes; soft reset clears the read mode byte
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			crm_q <= 8'h00;
			chk_addr_q <= 20'h00000;
		end
		else
		begin
			if (soft_go)
				crm_q <= 8'h00;
			else if (wr_pend_q & (wa_q == fp_pkg::REG_MODE))
				crm_q <= hwdata[7:0];
			if (wr_pend_q & (wa_q == fp_pkg::REG_CHECK))
				chk_addr_q <= hwdata[19:0];
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign op_req = op_q;
	assign core_abort = abort_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_refuse;
		exec & arr_op & hit |=> !op_q.valid;
	endproperty
	a_refuse: assert property (p_refuse) else $error("protected op issued");

	property p_wsr_only;
		$changed(bp_q) || $changed(protect_complement_bit_q) |-> $past(wrsr);
	endproperty
	a_wsr_only: assert property (p_wsr_only) else $error("protect bits moved");

	property p_upper16;
		!protect_complement_bit_q && bp_q == 5'h01 |-> chk_hit == (chk_addr_q >= 20'hf0000);
	endproperty
	a_upper16: assert property (p_upper16) else $error("upper sixteenth wrong");

	property p_top4k;
		!protect_complement_bit_q && bp_q == 5'h11 |-> chk_hit == (chk_addr_q >= 20'hff000);
	endproperty
	a_top4k: assert property (p_top4k) else $error("top 4K wrong");

	property p_none;
		!protect_complement_bit_q && bp_q[2:0] == 3'h0 |-> !chk_hit;
	endproperty
	a_none: assert property (p_none) else $error("zero code protects");

	property p_complement_all;
		protect_complement_bit_q && bp_q[2:0] == 3'h0 |-> chk_hit;
	endproperty
	a_complement_all: assert property (p_complement_all) else $error("complement zero not all");

	property p_wp_lock;
		wrsr && !wp_q[1] |=> $stable(bp_q) && $stable(protect_complement_bit_q);
	endproperty
	a_wp_lock: assert property (p_wp_lock) else $error("locked bits changed");

	property p_disarm;
		exec && opc_q != fp_pkg::OPC_RSTEN |=> !armed_q;
	endproperty
	a_disarm: assert property (p_disarm) else $error("reset still armed");

	property p_clear;
		soft_go |=> !write_enable_latch_q && !esus_q && !psus_q && crm_q == 8'h00
			&& wrap_q == 3'h0 && core_abort;
	endproperty
	a_clear: assert property (p_clear) else $error("soft reset left state");

	property p_recover;
		soft_go |=> rst_busy [*8] ##[RST_TAIL:RST_TAIL] !rst_busy;
	endproperty
	a_recover: assert property (p_recover) else $error("recovery time wrong");

	property p_sec;
		exec && is_sec && wr_ok && sec_ok |=> op_q.valid;
	endproperty
	a_sec: assert property (p_sec) else $error("security op dropped");

	property p_sec_lock;
		exec && is_sec && sec_lock |=> !op_q.valid;
	endproperty
	a_sec_lock: assert property (p_sec_lock) else $error("locked page altered");

	property p_write_enable;
		op_q.valid |-> $past(write_enable_latch_q);
	endproperty
	a_write_enable: assert property (p_write_enable) else $error("op without write enable");
endmodule

// ===== design/fp_pkg.sv
package fp_pkg;
	// Array geometry
	localparam int ADDR_W = 20;

	// Serial command opcodes
	localparam logic [7:0] OPC_WRSR = 8'h01;
	localparam logic [7:0] OPC_PP = 8'h02;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_BE4 = 8'h20;
	localparam logic [7:0] OPC_QPP = 8'h32;
	localparam logic [7:0] OPC_SECP = 8'h42;
	localparam logic [7:0] OPC_SECE = 8'h44;
	localparam logic [7:0] OPC_BE32 = 8'h52;
	localparam logic [7:0] OPC_CE1 = 8'h60;
	localparam logic [7:0] OPC_RSTEN = 8'h66;
	localparam logic [7:0] OPC_SUSP = 8'h75;
	localparam logic [7:0] OPC_WRAP = 8'h77;
	localparam logic [7:0] OPC_RESUME = 8'h7a;
	localparam logic [7:0] OPC_RST = 8'h99;
	localparam logic [7:0] OPC_CE2 = 8'hc7;
	localparam logic [7:0] OPC_BE64 = 8'hd8;

	// Register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MODE = 8'h04;
	localparam logic [7:0] REG_CHECK = 8'h08;
	localparam logic [7:0] REG_LASTOP = 8'h0c;

	// Field positions inside the status-write bytes and the wrap command byte
	localparam int SR_BP_LSB = 2;
	localparam int SR_LB_LSB = 3;
	localparam int SR_COMPLEMENT_BIT = 6;
	localparam int WRAP_LSB = 4;

	// Values after reset
	localparam logic [4:0] BP_RST = 5'h00;
	localparam logic COMPLEMENT_RST = 1'b0;
	localparam logic [2:0] LB_RST = 3'h0;

	// Protected-size exponents and operation masks
	localparam logic [4:0] SH_LARGE = 5'h10;
	localparam logic [4:0] SH_SMALL = 5'h0c;
	localparam logic [19:0] MASK_PAGE = 20'h000ff;
	localparam logic [19:0] MASK_4K = 20'h00fff;
	localparam logic [19:0] MASK_32K = 20'h07fff;
	localparam logic [19:0] MASK_64K = 20'h0ffff;
	localparam logic [19:0] MASK_CHIP = 20'hfffff;
	localparam logic [3:0] SEC_PAGE_FIRST = 4'h1;
	localparam logic [3:0] SEC_PAGE_LAST = 4'h3;

	// Frame byte counts
	localparam logic [2:0] NB_ONE = 3'h1;
	localparam logic [2:0] NB_WRSR1 = 3'h2;
	localparam logic [2:0] NB_WRSR2 = 3'h3;
	localparam logic [2:0] NB_ADDR = 3'h4;
	localparam logic [2:0] NB_WRAP = 3'h5;
	localparam logic [2:0] NB_MAX = 3'h7;

	// Soft reset recovery time
	localparam int CLK_PERIOD_NS = 50;
	localparam int RST_TIME_NS = 30000;
	localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = $clog2(RST_CYCLES + 1);

	typedef enum logic [2:0] {
		OP_PROG = 3'b000,
		OP_ER4K = 3'b001,
		OP_ER32K = 3'b010,
		OP_ER64K = 3'b011,
		OP_CHIP = 3'b100,
		OP_SECP = 3'b101,
		OP_SECE = 3'b110
	} op_kind_t;

	typedef struct packed {
		logic valid;
		op_kind_t kind;
		logic [ADDR_W-1:0] addr;
	} op_req_t;
endpackage

// ===== design/prot_decode.sv
`timescale 1ns/1ps
// Decodes the protect code into a hit for one address
module prot_decode #(
	parameter int AW = 20
) (
	input wire logic [4:0] bp,
	input wire logic protect_complement_bit,
	input wire logic [AW-1:0] addr,
	output logic hit
);
	logic [1:0] idx;
	logic [4:0] sh;
	logic [AW:0] size;
	logic [AW:0] top_base;
	logic none;
	logic all;
	logic region;

	// Size exponent from bits 4 and 2..0
	assign idx = bp[2] ? 2'h3 : 2'(bp[1:0] - 2'h1);
	assign sh = (bp[4] ? fp_pkg::SH_SMALL : fp_pkg::SH_LARGE) + {3'h0, idx};
	assign size = (AW+1)'(1) << sh;
	assign top_base = ((AW+1)'(1) << AW) - size;
	// Whole-array and empty codes
	assign none = bp[2:0] == 3'h0;
	assign all = (bp[2:1] == 2'h3) | (!bp[4] & (bp[2:0] == 3'h5));
	// Bit 3 selects bottom or top of the array
	assign region = all | (!none & (bp[3] ? ({1'b0, addr} < size) : ({1'b0, addr} >= top_base)));
	// Complement bit inverts the protected set
	assign hit = region ^ protect_complement_bit;
endmodule

// ===== tb/spi_host_model.sv
`timescale 1ns/1ps
// Host side of the serial link: mode 0, link clock idles low outside frames
module spi_host_model (
	input wire logic hclk,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi
);
	initial
	begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// Sends the leading bytes of a left-aligned frame, most significant bit first
	task automatic send(input logic [55:0] f, input int nbytes);
		spi_cs_n <= 1'b0;
		repeat (4) @(posedge hclk);
		for (int i = 0; i < nbytes * 8; i++)
		begin
			spi_mosi <= f[55 - i];
			repeat (4) @(posedge hclk);
			spi_sck <= 1'b1;
			repeat (4) @(posedge hclk);
			spi_sck <= 1'b0;
		end
		repeat (4) @(posedge hclk);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi; // Idle line never repeats the last bit
		repeat (12) @(posedge hclk);
	endtask

	// Opcode followed by a three-byte address
	task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int nbytes);
		send({opc, a, 24'h0}, nbytes);
	endtask

	// Write enable ahead of a write-class command
	task automatic wren();
		send({fp_pkg::OPC_WREN, 48'h0}, 1);
	endtask

	// Status write carrying protect code, complement and page locks
	task automatic wrsr(input logic [4:0] bp, input logic complement, input logic [2:0] lock);
		send({fp_pkg::OPC_WRSR, 1'b0, bp, 2'b00, 1'b0, complement, lock, 3'b000, 32'h0}, 3);
	endtask

	// Reset enable immediately followed by reset execute
	task automatic reset_pair();
		send({fp_pkg::OPC_RSTEN, 48'h0}, 1);
		send({fp_pkg::OPC_RST, 48'h0}, 1);
	endtask
endmodule

// ===== tb/flash_protect_reset_test.sv
`timescale 1ns/1ps
// Self-checking bench for protection decoding and soft reset
module flash_protect_reset_test;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wp_n;
	logic spi_sck, spi_cs_n, spi_mosi, core_busy, core_erase_active, core_abort;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [47:0] e;
	fp_pkg::op_req_t op_req, last_op;
	int num_errors, samples_checked, cycles, ops, aborts, n;
	// Entries: complement, code, probe address, protected, probe address, protected
	localparam logic [47:0] prot_tab [11] = '{
		{1'b0, 5'h01, 20'hf0000, 1'b1, 20'heffff, 1'b0},
		{1'b0, 5'h0c, 20'h7ffff, 1'b1, 20'h80000, 1'b0},
		{1'b0, 5'h1d, 20'h07fff, 1'b1, 20'h08000, 1'b0},
		{1'b0, 5'h00, 20'h00000, 1'b0, 20'hfffff, 1'b0},
		{1'b0, 5'h05, 20'h00000, 1'b1, 20'hfffff, 1'b1},
		{1'b0, 5'h16, 20'h00000, 1'b1, 20'hfffff, 1'b1},
		{1'b1, 5'h01, 20'heffff, 1'b1, 20'hf0000, 1'b0},
		{1'b1, 5'h00, 20'h00000, 1'b1, 20'hfffff, 1'b1},
		{1'b1, 5'h06, 20'h00000, 1'b0, 20'hfffff, 1'b0},
		{1'b1, 5'h19, 20'h01000, 1'b1, 20'h00fff, 1'b0},
		{1'b0, 5'h11, 20'hff000, 1'b1, 20'hfefff, 1'b0}};

	assign hready = hreadyout;

	flash_protect_reset flash_protect_reset_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n),
		.core_busy(core_busy), .core_erase_active(core_erase_active), .op_req(op_req),
		.core_abort(core_abort));

	spi_host_model spi_host_model_i (.hclk(hclk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi));

	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// Counts cycles, request pulses and abort pulses; cuts a hang short
	always @(posedge hclk)
	begin
		cycles++;
		if (op_req.valid === 1'b1)
		begin
			ops++;
			last_op = op_req;
		end
		if (core_abort === 1'b1)
			aborts++;
		if (cycles == 40000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Single word transfer; read data taken at the edge ending the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic read_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input string what);
		ahb(1'b0, a, 32'h0);
		check(what, x, rd & m);
	endtask

	// Loads the probe address, then reads back its protected flag
	task automatic probe(input logic [19:0] a, input logic x);
		ahb(1'b1, fp_pkg::REG_CHECK, {12'h0, a});
		repeat (2) @(posedge hclk);
		read_chk(fp_pkg::REG_CHECK, 32'h80000000, {x, 31'h0}, "protected flag");
	endtask

	// Issues one write-class command and checks whether it reached the core
	task automatic issue(input logic we, input logic [7:0] opc, input logic [23:0] a,
		input int nb, input logic ok, input fp_pkg::op_kind_t k);
		n = ops;
		if (we)
			spi_host_model_i.wren();
		spi_host_model_i.cmd(opc, a, nb);
		check("request count", n + ok, ops);
		read_chk(fp_pkg::REG_LASTOP, 32'h80000000, {~ok, 31'h0}, "refused flag");
		read_chk(fp_pkg::REG_STATUS, 32'h2, 32'h0, "write enable latch");
		if (ok)
			check("request", {9'h0, k, a[19:0]}, {9'h0, last_op.kind, last_op.addr});
	endtask

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		wp_n = 1'b1;
		core_busy = 1'b0;
		core_erase_active = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		read_chk(fp_pkg::REG_STATUS, 32'h3ffff, 32'h0, "status after reset");
		ahb(1'b1, 8'h40, 32'hffffffff);
		read_chk(8'h40, 32'hffffffff, 32'h0, "unmapped word");
		check("response", 32'h0, {31'h0, hresp});
		issue(1'b0, fp_pkg::OPC_PP, 24'h000100, 4, 1'b0, fp_pkg::OP_PROG);
		// Protect codes decoded into ranges, probed on both sides of each boundary
		for (int i = 0; i < 11; i++)
		begin
			e = prot_tab[i];
			spi_host_model_i.wren();
			spi_host_model_i.wrsr(e[46:42], e[47], 3'h0);
			read_chk(fp_pkg::REG_STATUS, 32'h407c, {17'h0, e[47], 7'h0, e[46:42], 2'b00},
				"protect bits");
			probe(e[41:22], e[21]);
			probe(e[20:1], e[0]);
		end
		issue(1'b1, fp_pkg::OPC_PP, 24'h0ff010, 4, 1'b0, fp_pkg::OP_PROG);
		issue(1'b1, fp_pkg::OPC_BE4, 24'h0fe000, 4, 1'b1, fp_pkg::OP_ER4K);
		issue(1'b1, fp_pkg::OPC_CE1, 24'h000000, 1, 1'b0, fp_pkg::OP_CHIP);
		spi_host_model_i.wren();
		spi_host_model_i.wrsr(5'h05, 1'b0, 3'h1);
		issue(1'b1, fp_pkg::OPC_SECE, 24'h001000, 4, 1'b0, fp_pkg::OP_SECE);
		issue(1'b1, fp_pkg::OPC_SECP, 24'h002000, 4, 1'b1, fp_pkg::OP_SECP);
		// Lock pin low: protect bits frozen, decoded protection kept
		wp_n <= 1'b0;
		repeat (4) @(posedge hclk);
		spi_host_model_i.wren();
		spi_host_model_i.wrsr(5'h00, 1'b1, 3'h0);
		read_chk(fp_pkg::REG_STATUS, 32'h407c, 32'h14, "frozen protect bits");
		probe(20'h00000, 1'b1);
		wp_n <= 1'b1;
		repeat (4) @(posedge hclk);
		spi_host_model_i.wren();
		spi_host_model_i.wrsr(5'h00, 1'b0, 3'h0);
		read_chk(fp_pkg::REG_STATUS, 32'h407c, 32'h0, "released protect bits");
		// Volatile state set up ahead of the soft reset
		ahb(1'b1, fp_pkg::REG_MODE, 32'ha5);
		spi_host_model_i.send({fp_pkg::OPC_WRAP, 24'h0, 8'h70, 16'h0}, 5);
		core_busy <= 1'b1;
		core_erase_active <= 1'b1;
		spi_host_model_i.send({fp_pkg::OPC_SUSP, 48'h0}, 1);
		core_busy <= 1'b0;
		read_chk(fp_pkg::REG_STATUS, 32'h8000, 32'h8000, "erase suspended");
		// A program suspend on top, so the soft reset must clear both flags
		core_busy <= 1'b1;
		core_erase_active <= 1'b0;
		spi_host_model_i.send({fp_pkg::OPC_SUSP, 48'h0}, 1);
		core_busy <= 1'b0;
		read_chk(fp_pkg::REG_STATUS, 32'h8400, 32'h8400, "both suspended");
		spi_host_model_i.send({fp_pkg::OPC_RSTEN, 48'h0}, 1);
		spi_host_model_i.wren();
		spi_host_model_i.send({fp_pkg::OPC_RST, 48'h0}, 1);
		check("aborts after broken pair", 32'h0, aborts);
		read_chk(fp_pkg::REG_MODE, 32'h7ff, 32'h7a5, "mode before reset");
		spi_host_model_i.reset_pair();
		check("aborts", 32'h1, aborts);
		read_chk(fp_pkg::REG_STATUS, 32'h38403, 32'h20001, "status in recovery");
		read_chk(fp_pkg::REG_MODE, 32'h7ff, 32'h0, "mode after reset");
		spi_host_model_i.wren();
		read_chk(fp_pkg::REG_STATUS, 32'h2, 32'h0, "enable in recovery");
		repeat (700) @(posedge hclk);
		read_chk(fp_pkg::REG_STATUS, 32'h20003, 32'h0, "status after recovery");
		spi_host_model_i.wren();
		read_chk(fp_pkg::REG_STATUS, 32'h2, 32'h2, "enable after recovery");
		report_and_stop();
	end
endmodule
